// ---- logic/pmco_core.sv ----
// Purpose: pin-override mask, programmable bus target address and settings
//          checksum commands, plus power-on and restore loading of settings
// Assumes: a transaction layer presents one decoded command per valid pulse
//          and asks for an address match on each address phase
// Notes:   answers come one clock after the request
`timescale 1ns/100ps

// Summary of operation
// - set mask bit keeps the strapped value
// - setting straps sampled only at power-on load; strap_addr is read again on restore
// - bit 12 picks stack setting source
// - bit 11 picks sync setting source
// - bit 9 picks compensation setting source
// - bit 8 picks follower address source
// - bit 5 picks phase_offset_setting setting source
// - bit 3 picks soft-start time source
// - bit 2 picks both overcurrent limits
// - bit 1 picks switching frequency source
// - bit 0 picks the four voltage settings
// - mask uses code ee, word access
// - address uses code ef, byte access
// - checksum code f0 is read only
// - new address answers at once, old refused
// - address is bits 6:0, loaded at boot
// - address bit 7 always reads zero
// - reserved addresses cannot be programmed
// - checksum is crc-16 polynomial 8005
// - checksum refreshed at boot, store, restore
module pmco_core (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // nonvolatile image
    input wire pmco_pkg::pmco_settings_s nvm_settings,
    input wire logic [15:0] nvm_mask,
    input wire logic [6:0] nvm_addr,
    input wire logic nvm_addr_valid,
    // strap detection
    input wire pmco_pkg::pmco_settings_s strap_settings,
    input wire logic [6:0] strap_addr,
    // nonvolatile events
    input wire logic restore_req,
    input wire logic store_done,
    // command port
    input wire pmco_pkg::pmco_cmd_s cmd,
    output pmco_pkg::pmco_rsp_s rsp,
    // address match
    input wire logic addr_probe_valid,
    input wire logic [6:0] addr_probe,
    output logic addr_match_valid,
    output logic addr_match,
    // status
    input wire logic inval_clear,
    output logic inval_flag,
    // live settings
    output pmco_pkg::pmco_settings_s live_settings,
    output logic [6:0] bus_addr,
    output logic boot_ready
);

    pmco_pkg::pmco_state_s st_reg;
    pmco_pkg::pmco_state_s st_next;
    logic crc_done;
    logic [15:0] crc_val;
    logic [pmco_pkg::CRC_IMG_W-1:0] crc_image;
    logic load_req;
    logic rsv_hit;
    logic inval_set;

    // per-group source choice on power-up and restore
    function automatic pmco_pkg::pmco_settings_s pick(
        input logic [15:0] m,
        input pmco_pkg::pmco_settings_s nv,
        input pmco_pkg::pmco_settings_s pin
    );
        pmco_pkg::pmco_settings_s r;
        r = nv;
        if (m[pmco_pkg::MB_STACK]) begin
            r.stack = pin.stack;
        end
        if (m[pmco_pkg::MB_SYNC]) begin
            r.sync = pin.sync;
        end
        if (m[pmco_pkg::MB_COMP]) begin
            r.comp = pin.comp;
        end
        if (m[pmco_pkg::MB_FOLLOW]) begin
            r.follow_addr = pin.follow_addr;
        end
        if (m[pmco_pkg::MB_ILV]) begin
            r.phase_offset_setting = pin.phase_offset_setting;
        end
        if (m[pmco_pkg::MB_TON]) begin
            r.soft_start_time = pin.soft_start_time;
        end
        if (m[pmco_pkg::MB_OC]) begin
            r.oc_fault = pin.oc_fault;
            r.oc_warn = pin.oc_warn;
        end
        if (m[pmco_pkg::MB_SWITCH_RATE_MASK_BIT]) begin
            r.switch_rate_mask_bit = pin.switch_rate_mask_bit;
        end
        if (m[pmco_pkg::MB_VOUT]) begin
            r.vout_cmd = pin.vout_cmd;
            r.vout_scale = pin.vout_scale;
            r.vout_max = pin.vout_max;
            r.vout_min = pin.vout_min;
        end
        return r;
    endfunction

    // the checksum covers what is stored, not what is live
    assign crc_image = {nvm_settings, nvm_mask, 1'b0, nvm_addr};

    always_comb begin
        rsv_hit = 1'b0;
        if (cmd.wdata[6:0] == pmco_pkg::RSV_ADDR0) begin
            rsv_hit = 1'b1;
        end else if (cmd.wdata[6:0] == pmco_pkg::RSV_ADDR1) begin
            rsv_hit = 1'b1;
        end else if (cmd.wdata[6:0] == pmco_pkg::RSV_ADDR2) begin
            rsv_hit = 1'b1;
        end else if (cmd.wdata[6:0] == pmco_pkg::RSV_ADDR3) begin
            rsv_hit = 1'b1;
        end
    end

    assign load_req = (st_reg.boot == pmco_pkg::ST_CRC) || (st_reg.boot == pmco_pkg::ST_IDLE);

    always_comb begin
        st_next = st_reg;
        st_next.crc_start = 1'b0;
        st_next.rsp = '0;
        st_next.match_valid = 1'b0;
        st_next.match = 1'b0;
        inval_set = 1'b0;

        case (st_reg.boot)
            pmco_pkg::ST_RESET: begin
                st_next.boot = pmco_pkg::ST_LOAD;
            end
            pmco_pkg::ST_LOAD: begin
                // straps caught once, after reset release
                st_next.strap = strap_settings;
                st_next.live = pick(nvm_mask, nvm_settings, strap_settings);
                st_next.mask = nvm_mask;
                // initial address from store or strap
                st_next.addr = nvm_addr_valid ? nvm_addr : strap_addr;
                st_next.crc_start = 1'b1;
                st_next.boot = pmco_pkg::ST_CRC;
            end
            pmco_pkg::ST_CRC: begin
                if (crc_done) begin
                    st_next.crc = crc_val;
                    st_next.ready = 1'b1;
                    st_next.boot = pmco_pkg::ST_IDLE;
                end
            end
            default: begin
                st_next.ready = 1'b1;
            end
        endcase

        if (load_req && restore_req) begin
            // restore reuses the captured setting straps; only strap_addr is read again from the pins
            st_next.live = pick(nvm_mask, nvm_settings, st_reg.strap);
            st_next.mask = nvm_mask;
            st_next.addr = nvm_addr_valid ? nvm_addr : strap_addr;
        end
        if (load_req && (restore_req || store_done)) begin
            st_next.crc_start = 1'b1;
            st_next.boot = pmco_pkg::ST_CRC;
        end

        // compare against the address in force this cycle
        if (addr_probe_valid) begin
            st_next.match_valid = 1'b1;
            st_next.match = load_req && (addr_probe == st_reg.addr);
        end

        if (cmd.valid) begin
            st_next.rsp.valid = 1'b1;
            if (!load_req) begin
                st_next.rsp.nack = 1'b1;
            end else if (cmd.code == pmco_pkg::CMD_PIN_OVR) begin
                if (cmd.write) begin
                    // kept for readback only, loads take nvm_mask; no new strap sampling
                    st_next.mask = cmd.wdata;
                end else begin
                    st_next.rsp.data = st_reg.mask;
                end
            end else if (cmd.code == pmco_pkg::CMD_BUS_ADDR) begin
                if (cmd.write) begin
                    if (rsv_hit) begin
                        st_next.inval = 1'b1;
                        inval_set = 1'b1;
                    end else begin
                        st_next.addr = cmd.wdata[6:0];
                    end
                end else begin
                    st_next.rsp.data = {8'h00, 1'b0, st_reg.addr};
                end
            end else if (cmd.code == pmco_pkg::CMD_CRC) begin
                if (cmd.write) begin
                    st_next.rsp.nack = 1'b1;
                    st_next.inval = 1'b1;
                    inval_set = 1'b1;
                end else begin
                    st_next.rsp.data = st_reg.crc;
                end
            end else begin
                st_next.rsp.nack = 1'b1;
            end
        end

        // a new event in the clearing cycle wins, even when the flag already stands
        if (inval_clear && !inval_set) begin
            st_next.inval = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.boot <= pmco_pkg::ST_RESET;
            st_reg.mask <= pmco_pkg::MASK_RST;
            st_reg.addr <= pmco_pkg::ADDR_RST;
            st_reg.crc <= pmco_pkg::CRC_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    pmco_crc u_crc (
        .mclk(mclk),
        .arst_n(arst_n),
        .start(st_reg.crc_start),
        .image(crc_image),
        .done(crc_done),
        .crc(crc_val)
    );

    assign rsp = st_reg.rsp;
    assign addr_match_valid = st_reg.match_valid;
    assign addr_match = st_reg.match;
    assign inval_flag = st_reg.inval;
    assign live_settings = st_reg.live;
    assign bus_addr = st_reg.addr;
    assign boot_ready = st_reg.ready;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence seq_addr_write;
        cmd.valid && cmd.write && (cmd.code == pmco_pkg::CMD_BUS_ADDR) && load_req;
    endsequence

    sequence seq_crc_run;
        st_reg.crc_start ##[21:22] (st_reg.boot == pmco_pkg::ST_IDLE);
    endsequence

    chk_strap_hold: assert property (
        (st_reg.boot == pmco_pkg::ST_IDLE) |=> $stable(st_reg.strap))
        else $error("straps changed after power-on load");

    chk_stack_src: assert property (
        (st_reg.boot == pmco_pkg::ST_LOAD) |=> (st_reg.live.stack ==
        ($past(nvm_mask[12]) ? $past(strap_settings.stack) : $past(nvm_settings.stack))))
        else $error("stack setting from wrong source");

    chk_sync_src: assert property (
        (load_req && restore_req) |=> (st_reg.live.sync ==
        ($past(nvm_mask[11]) ? $past(st_reg.strap.sync) : $past(nvm_settings.sync))))
        else $error("sync setting from wrong source on restore");

    chk_oc_pair: assert property (
        (load_req && restore_req && nvm_mask[2]) |=>
        (st_reg.live.oc_fault == st_reg.strap.oc_fault) &&
        (st_reg.live.oc_warn == st_reg.strap.oc_warn))
        else $error("overcurrent limits not taken together");

    chk_vout_group: assert property (
        (load_req && restore_req && !nvm_mask[0]) |=>
        (st_reg.live.vout_cmd == $past(nvm_settings.vout_cmd)) &&
        (st_reg.live.vout_min == $past(nvm_settings.vout_min)))
        else $error("voltage group not reloaded from store");

    chk_addr_switch: assert property (
        (seq_addr_write and (!rsv_hit)) |=> (st_reg.addr == $past(cmd.wdata[6:0]))
        ##1 (!st_reg.match_valid || st_reg.match == ($past(addr_probe) == st_reg.addr)))
        else $error("address not switched at once");

    chk_addr_rsv: assert property (
        (seq_addr_write and rsv_hit) |=> $stable(st_reg.addr) && st_reg.inval)
        else $error("reserved address accepted");

    chk_bit7_zero: assert property (
        (cmd.valid && !cmd.write && cmd.code == pmco_pkg::CMD_BUS_ADDR && load_req)
        |=> rsp.valid && !rsp.data[7])
        else $error("address bit 7 read as one");

    chk_crc_nowrite: assert property (
        (cmd.valid && cmd.write && cmd.code == pmco_pkg::CMD_CRC) |=> rsp.valid && rsp.nack)
        else $error("checksum write not refused");

    chk_crc_refresh: assert property (
        (load_req && store_done && !restore_req && !cmd.valid) |=> seq_crc_run)
        else $error("checksum not refreshed after store");

    chk_inval_wins: assert property (
        (cmd.valid && cmd.write && cmd.code == pmco_pkg::CMD_CRC && load_req && inval_clear)
        |=> inval_flag)
        else $error("invalid-data flag lost to a clear");

    chk_mask_write: assert property (
        (cmd.valid && cmd.write && cmd.code == pmco_pkg::CMD_PIN_OVR && load_req)
        |=> (st_reg.mask == $past(cmd.wdata)))
        else $error("override mask write not taken");

    chk_switch_rate_mask_bit_src: assert property (
        (st_reg.boot == pmco_pkg::ST_LOAD) |=> (st_reg.live.switch_rate_mask_bit ==
        ($past(nvm_mask[pmco_pkg::MB_SWITCH_RATE_MASK_BIT]) ? $past(strap_settings.switch_rate_mask_bit) : $past(nvm_settings.switch_rate_mask_bit))))
        else $error("frequency setting from wrong source");

endmodule

// ---- logic/pmco_pkg.sv ----
// Purpose: shared constants and carriers for the pin-override, bus-address and
//          settings-checksum command block
// Assumes: a PMBus transaction layer decodes frames into one command per pulse
// Notes:   widths of the live settings are fixed; the crc covers a 20-byte image
package pmco_pkg;

    // command codes
    localparam logic [7:0] CMD_PIN_OVR = 8'hee;
    localparam logic [7:0] CMD_BUS_ADDR = 8'hef;
    localparam logic [7:0] CMD_CRC = 8'hf0;

    // positions of the override mask bits
    localparam int MB_VOUT = 0;
    localparam int MB_SWITCH_RATE_MASK_BIT = 1;
    localparam int MB_OC = 2;
    localparam int MB_TON = 3;
    localparam int MB_ILV = 5;
    localparam int MB_FOLLOW = 8;
    localparam int MB_COMP = 9;
    localparam int MB_SYNC = 11;
    localparam int MB_STACK = 12;

    // reserved target addresses that cannot be programmed
    localparam logic [6:0] RSV_ADDR0 = 7'h0c;
    localparam logic [6:0] RSV_ADDR1 = 7'h28;
    localparam logic [6:0] RSV_ADDR2 = 7'h37;
    localparam logic [6:0] RSV_ADDR3 = 7'h61;

    // reset values before the power-on load
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic [15:0] CRC_RST = 16'h0000;

    // checksum engine
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam int CRC_BYTES = 20;
    localparam int CRC_IMG_W = 160;

    typedef struct packed {
        logic [7:0] stack;
        logic [7:0] sync;
        logic [7:0] comp;
        logic [7:0] follow_addr;
        logic [7:0] phase_offset_setting;
        logic [7:0] soft_start_time;
        logic [7:0] oc_fault;
        logic [7:0] oc_warn;
        logic [7:0] switch_rate_mask_bit;
        logic [15:0] vout_cmd;
        logic [15:0] vout_scale;
        logic [15:0] vout_max;
        logic [15:0] vout_min;
    } pmco_settings_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } pmco_cmd_s;

    typedef struct packed {
        logic valid;
        logic nack;
        logic [15:0] data;
    } pmco_rsp_s;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_LOAD = 2'b01,
        ST_CRC = 2'b11,
        ST_IDLE = 2'b10
    } pmco_boot_e;

    typedef struct packed {
        pmco_boot_e boot;
        pmco_settings_s strap;
        pmco_settings_s live;
        logic [15:0] mask;
        logic [6:0] addr;
        pmco_rsp_s rsp;
        logic match_valid;
        logic match;
        logic inval;
        logic [15:0] crc;
        logic crc_start;
        logic ready;
    } pmco_state_s;

    typedef struct packed {
        logic busy;
        logic [4:0] idx;
        logic [15:0] crc;
        logic done;
    } pmco_crc_state_s;

endpackage

// ---- logic/pmco_crc.sv ----
// Purpose: byte-serial crc-16 over the nonvolatile settings image
// Assumes: image is held stable from start until done
// Notes:   msb-first, no reflection, zero seed; one byte per clock
`timescale 1ns/100ps
module pmco_crc (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // control
    input wire logic start,
    input wire logic [pmco_pkg::CRC_IMG_W-1:0] image,
    // result
    output logic done,
    output logic [15:0] crc
);

    pmco_pkg::pmco_crc_state_s st_reg;
    pmco_pkg::pmco_crc_state_s st_next;
    logic [7:0] cur_byte;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ pmco_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    assign cur_byte = image[(pmco_pkg::CRC_BYTES - 1 - int'(st_reg.idx)) * 8 +: 8];

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (start) begin
            // a new start restarts the walk so a late store is never missed
            st_next.busy = 1'b1;
            st_next.idx = 5'h00;
            st_next.crc = pmco_pkg::CRC_INIT;
        end else if (st_reg.busy) begin
            st_next.crc = crc_byte(st_reg.crc, cur_byte);
            if (st_reg.idx == 5'(pmco_pkg::CRC_BYTES - 1)) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.idx = st_reg.idx + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign done = st_reg.done;
    assign crc = st_reg.crc;

endmodule

// ---- testbench/pmco_host.sv ----
// Purpose: host controller model that issues decoded read and write commands
// Assumes: one request at a time, the answer is read at the falling edge after it is taken
// Notes:   changes its request just after a falling edge, holds it through the taking edge
`timescale 1ns/100ps
module pmco_host (
    // clock
    input wire logic mclk,
    // command side
    output pmco_pkg::pmco_cmd_s cmd,
    input wire pmco_pkg::pmco_rsp_s rsp
);
    initial begin
        cmd = '0;
    end

    // a missing answer comes back as an unknown refusal flag, so no check can pass on it
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
            output logic [15:0] rd, output logic nk);
        logic [15:0] v;
        v = wd;
        if (code == pmco_pkg::CMD_PIN_OVR) v = wd & 16'h1f3f;
        if (code == pmco_pkg::CMD_BUS_ADDR) v = {8'h00, wd[7:0]};
        // checksum is read as a word
        @(negedge mclk);
        cmd = '{valid: 1'b1, write: wr, code: code, wdata: v};
        @(posedge mclk);
        @(negedge mclk);
        cmd = '0;
        // the answer stands only until the next rising edge
        rd = rsp.data;
        nk = (rsp.valid === 1'b1) ? rsp.nack : 1'bx;
    endtask
endmodule

// ---- testbench/pmbus_pin_override_address_checksum_test.sv ----
// Purpose: self-checking bench for the override mask, target address and checksum
// Assumes: inputs change at the falling edge; answers looked at the falling edge after the taking rising edge
// Notes:   checksum expectation is a bitwise model, independent of the byte engine
`timescale 1ns/100ps
module pmbus_pin_override_address_checksum_test;
    logic mclk;
    logic arst_n;
    pmco_pkg::pmco_settings_s nvm_settings;
    pmco_pkg::pmco_settings_s strap_settings;
    pmco_pkg::pmco_settings_s strap0;
    logic [15:0] nvm_mask;
    logic [6:0] nvm_addr;
    logic nvm_addr_valid;
    logic [6:0] strap_addr;
    logic restore_req;
    logic store_done;
    pmco_pkg::pmco_cmd_s cmd;
    pmco_pkg::pmco_rsp_s rsp;
    logic addr_probe_valid;
    logic [6:0] addr_probe;
    logic addr_match_valid;
    logic addr_match;
    logic inval_clear;
    logic inval_flag;
    pmco_pkg::pmco_settings_s live_settings;
    logic [6:0] bus_addr;
    logic boot_ready;
    logic [15:0] rd;
    logic nk;
    logic m;
    int n_mismatch;
    int tests_run;

    pmco_core i_pmco_core (.mclk(mclk), .arst_n(arst_n), .nvm_settings(nvm_settings),
        .nvm_mask(nvm_mask), .nvm_addr(nvm_addr), .nvm_addr_valid(nvm_addr_valid),
        .strap_settings(strap_settings), .strap_addr(strap_addr), .restore_req(restore_req),
        .store_done(store_done), .cmd(cmd), .rsp(rsp), .addr_probe_valid(addr_probe_valid),
        .addr_probe(addr_probe), .addr_match_valid(addr_match_valid),
        .addr_match(addr_match), .inval_clear(inval_clear), .inval_flag(inval_flag),
        .live_settings(live_settings), .bus_addr(bus_addr), .boot_ready(boot_ready));

    pmco_host i_pmco_host (.mclk(mclk), .cmd(cmd), .rsp(rsp));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input logic [135:0] seen, input logic [135:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic pmco_pkg::pmco_settings_s pick(input logic [15:0] mk,
            input pmco_pkg::pmco_settings_s nv, input pmco_pkg::pmco_settings_s pin);
        pmco_pkg::pmco_settings_s r;
        r = nv;
        if (mk[12]) r.stack = pin.stack;
        if (mk[11]) r.sync = pin.sync;
        if (mk[9]) r.comp = pin.comp;
        if (mk[8]) r.follow_addr = pin.follow_addr;
        if (mk[5]) r.phase_offset_setting = pin.phase_offset_setting;
        if (mk[3]) r.soft_start_time = pin.soft_start_time;
        if (mk[2]) {r.oc_fault, r.oc_warn} = {pin.oc_fault, pin.oc_warn};
        if (mk[1]) r.switch_rate_mask_bit = pin.switch_rate_mask_bit;
        if (mk[0]) {r.vout_cmd, r.vout_scale, r.vout_max, r.vout_min} =
            {pin.vout_cmd, pin.vout_scale, pin.vout_max, pin.vout_min};
        return r;
    endfunction

    // msb-first, zero seed, no final inversion
    function automatic logic [15:0] crc16(input logic [159:0] img);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 159; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ img[i]) ? 16'h8005 : 16'h0000);
        end
        return c;
    endfunction

    task automatic pulse(ref logic s);
        @(negedge mclk);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask

    task automatic probe(input logic [6:0] a, output logic mt);
        @(negedge mclk);
        addr_probe_valid = 1'b1;
        addr_probe = a;
        @(negedge mclk);
        addr_probe_valid = 1'b0;
        mt = (addr_match_valid === 1'b1) ? addr_match : 1'bx;
    endtask

    task automatic t_boot();
        for (int i = 0; i < 100 && boot_ready !== 1'b1; i++) @(posedge mclk);
        #1;
        check(boot_ready, 1'b1);
        check(bus_addr, 7'h11);
        check(live_settings, pick(16'h1b2f, nvm_settings, strap0));
        i_pmco_host.xfer(1'b0, 8'hee, 16'h0000, rd, nk);
        check({nk, rd}, {1'b0, 16'h1b2f});
    endtask

    // straps are changed after power-on; restores must still use the captured ones
    task automatic t_restore();
        logic [15:0] masks [3];
        masks = '{16'h0a25, 16'h110e, 16'h0000};
        @(negedge mclk);
        strap_settings = {17{8'h3c}};
        foreach (masks[k]) begin
            @(negedge mclk);
            nvm_mask = masks[k];
            pulse(restore_req);
            @(posedge mclk);
            #1;
            check(live_settings, pick(masks[k], nvm_settings, strap0));
        end
        i_pmco_host.xfer(1'b1, 8'hee, 16'hffff, rd, nk);
        i_pmco_host.xfer(1'b0, 8'hee, 16'h0000, rd, nk);
        check({nk, rd}, {1'b0, 16'h1f3f});
        check(live_settings, nvm_settings);
    endtask

    task automatic t_addr();
        logic [6:0] rsv [4];
        rsv = '{7'h0c, 7'h28, 7'h37, 7'h61};
        i_pmco_host.xfer(1'b1, 8'hef, 16'h00a2, rd, nk);
        check(nk, 1'b0);
        probe(7'h22, m);
        check(m, 1'b1);
        probe(7'h11, m);
        check(m, 1'b0);
        i_pmco_host.xfer(1'b0, 8'hef, 16'h0000, rd, nk);
        check({nk, rd}, {1'b0, 16'h0022});
        foreach (rsv[k]) begin
            i_pmco_host.xfer(1'b1, 8'hef, {9'h000, rsv[k]}, rd, nk);
            check(bus_addr, 7'h22);
            check(inval_flag, 1'b1);
            pulse(inval_clear);
            #1;
            check(inval_flag, 1'b0);
        end
    endtask

    task automatic t_crc();
        // let the checksum started by the last restore settle
        repeat (30) @(negedge mclk);
        i_pmco_host.xfer(1'b0, 8'hf0, 16'h0000, rd, nk);
        check({nk, rd}, {1'b0, crc16({nvm_settings, nvm_mask, 1'b0, nvm_addr})});
        i_pmco_host.xfer(1'b1, 8'hf0, 16'h1234, rd, nk);
        check({nk, inval_flag}, 2'b11);
        // a second refused write meets a clear while the flag already stands
        fork
            i_pmco_host.xfer(1'b1, 8'hf0, 16'h1234, rd, nk);
            pulse(inval_clear);
        join
        check(inval_flag, 1'b1);
        pulse(inval_clear);
        i_pmco_host.xfer(1'b0, 8'he0, 16'h0000, rd, nk);
        check(nk, 1'b1);
        @(negedge mclk);
        nvm_settings.switch_rate_mask_bit = 8'hc7;
        pulse(store_done);
        repeat (40) @(posedge mclk);
        i_pmco_host.xfer(1'b0, 8'hf0, 16'h0000, rd, nk);
        check({nk, rd}, {1'b0, crc16({nvm_settings, nvm_mask, 1'b0, nvm_addr})});
    endtask

    // host clears bit 12, stores, then cycles power
    task automatic t_stack_nvm();
        i_pmco_host.xfer(1'b1, 8'hee, 16'h0b2f, rd, nk);
        check(nk, 1'b0);
        @(negedge mclk);
        nvm_mask = 16'h0b2f;
        nvm_addr_valid = 1'b0;
        pulse(store_done);
        @(negedge mclk);
        arst_n = 1'b0;
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        check(boot_ready, 1'b0);
        for (int i = 0; i < 100 && boot_ready !== 1'b1; i++) @(posedge mclk);
        #1;
        check(live_settings.stack, nvm_settings.stack);
        check(live_settings, pick(16'h0b2f, nvm_settings, strap_settings));
        check(bus_addr, 7'h44);
    endtask

    initial begin
        #100000;
        n_mismatch++;
        results();
    end

    initial begin
        n_mismatch = 0;
        tests_run = 0;
        arst_n = 1'b0;
        nvm_settings = {17{8'h5a}};
        strap0 = {17{8'ha3}};
        strap_settings = strap0;
        nvm_mask = 16'h1b2f;
        nvm_addr = 7'h11;
        nvm_addr_valid = 1'b1;
        strap_addr = 7'h44;
        restore_req = 1'b0;
        store_done = 1'b0;
        addr_probe_valid = 1'b0;
        addr_probe = 7'h00;
        inval_clear = 1'b0;
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        t_boot();
        t_restore();
        t_addr();
        t_crc();
        t_stack_nvm();
        results();
    end
endmodule
